// ### ssw_pkg.sv
// Constants, register map and state types of the two/three-wire serial port
// ============================================================================
package ssw_pkg;

    // ========================================================================
    // Register map: word indices, byte address is four times the index
    localparam int          AXI_ADDR_W    = 20;
    localparam int          IDX_W         = 18;
    localparam logic [17:0] IDX_PORT_DIR  = 18'h0_ffa7;
    localparam logic [17:0] IDX_SHIFT     = 18'h0_ffa8;
    localparam logic [17:0] IDX_STATUS    = 18'h0_ffa9;
    localparam logic [17:0] IDX_CONTROL   = 18'h0_ffaa;
    localparam logic [17:0] IDX_WIRE_MODE = 18'h0_ffab;

    // ========================================================================
    // Fields and reset values
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_MASK   = 8'h87;
    localparam logic [7:0] SHIFT_RESET    = 8'h00;
    localparam logic [1:0] PORT_DIR_RESET = 2'h0;
    localparam int         ENABLE_BIT     = 7;
    localparam int         RX_ONLY_BIT    = 2;
    localparam int         CLK_DIR_BIT    = 0;
    localparam int         DATA_DIR_BIT   = 1;
    localparam int         DONE_BIT       = 0;

    // ========================================================================
    // Clock sources and timing
    localparam logic [1:0] CLK_EXTERNAL = 2'h0;
    localparam logic [1:0] CLK_TIMER    = 2'h1;
    localparam logic [1:0] CLK_DIV_LO   = 2'h2;
    localparam logic [1:0] CLK_DIV_HI   = 2'h3;
    localparam int         DIV_LO_EXP   = 3;
    localparam int         DIV_HI_EXP   = 7;
    // Half a serial clock period, in system clocks, minus one
    localparam logic [6:0] DIV_LO_LAST  = 7'(2 ** (DIV_LO_EXP - 1) - 1);
    localparam logic [6:0] DIV_HI_LAST  = 7'(2 ** (DIV_HI_EXP - 1) - 1);
    localparam logic [3:0] XFER_BITS    = 4'h8;
    localparam int         FIFO_DEPTH   = 8;
    localparam int         DATA_W       = 8;

    // ========================================================================
    // Bus answers and engine states
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic {ST_IDLE, ST_SHIFT} ssw_state_type;

endpackage

// ### ssw_serial_port.sv
// Serial port engine with AXI4-Lite registers and its transmit FIFO
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// ============================================================================
// Transmit FIFO; DEPTH must be a power of two
module ssw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             clear,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ssw_fifo_state_type;

    ssw_fifo_state_type s;
    ssw_fifo_state_type n;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic [AW:0]        used;

    always_comb begin
        used      = s.wp - s.rp;
        in_ready  = (used != (AW + 1)'(DEPTH));
        out_valid = (s.wp != s.rp);
        out_data  = mem[s.rp[AW-1:0]];
        n         = s;
        if (in_valid && in_ready) begin
            n.wp = s.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            n.rp = s.rp + 1'b1;
        end
        if (clear) begin
            n.wp = '0;
            n.rp = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
        if (in_valid && in_ready) begin
            mem[s.wp[AW-1:0]] <= in_data;
        end
    end

endmodule

// ============================================================================
// Clock-synchronous serial port, top level
module ssw_serial_port #(
    parameter int FIFO_DEPTH = ssw_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [19:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [19:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Serial clock pin
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    // Data out pin, shared data pin in two-wire mode
    input  wire logic        data_out_pin_i,
    output logic             data_out_pin_o,
    output logic             data_out_pin_oe,
    // Data in pin and on-chip timer
    input  wire logic        data_in_pin_i,
    input  wire logic        timer_clock_output
);
    typedef struct packed {
        logic                  aw_rdy;
        logic [17:0]           aw_idx;
        logic                  w_rdy;
        logic [7:0]            w_data;
        logic                  w_lane0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  ar_rdy;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic [1:0]            rresp;
        logic [7:0]            control;
        logic                  wire_mode;
        logic [1:0]            port_dir;
        logic [7:0]            sh;
        logic                  done;
        ssw_pkg::ssw_state_type state;
        logic [3:0]            cnt;
        logic [6:0]            div;
        logic                  sck;
        logic                  out_bit;
        logic                  sck_oe;
        logic                  dout_oe;
        logic                  tmr_prev;
        logic [2:0]            sck_sync;
        logic                  sck_stable;
        logic [2:0]            din_sync;
        logic                  din_stable;
    } ssw_top_state_type;

    localparam ssw_top_state_type S_RESET = '{
        aw_rdy:     1'b1,
        aw_idx:     '0,
        w_rdy:      1'b1,
        w_data:     '0,
        w_lane0:    1'b0,
        bvalid:     1'b0,
        bresp:      ssw_pkg::RESP_OKAY,
        ar_rdy:     1'b1,
        rvalid:     1'b0,
        rdata:      '0,
        rresp:      ssw_pkg::RESP_OKAY,
        control:    ssw_pkg::CONTROL_RESET,
        wire_mode:  1'b0,
        port_dir:   ssw_pkg::PORT_DIR_RESET,
        sh:         ssw_pkg::SHIFT_RESET,
        done:       1'b0,
        state:      ssw_pkg::ST_IDLE,
        cnt:        '0,
        div:        '0,
        sck:        1'b1,
        out_bit:    1'b0,
        sck_oe:     1'b0,
        dout_oe:    1'b0,
        tmr_prev:   1'b0,
        sck_sync:   3'h7,
        sck_stable: 1'b1,
        din_sync:   '0,
        din_stable: 1'b0
    };

    ssw_top_state_type s;
    ssw_top_state_type n;

    logic       enable;
    logic       rx_only;
    logic [1:0] clk_src;
    logic       do_write;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_pop;
    logic [7:0] fifo_out_data;
    logic       rd_start;
    logic       ext_rise;
    logic       ext_fall;
    logic       tgl;
    logic       sck_fall;
    logic       sck_rise;
    logic [6:0] div_last;

    // ========================================================================
    // Transmit FIFO; a full FIFO holds the write response back
    ssw_fifo #(
        .WIDTH (ssw_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clear     (!enable),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (s.w_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // ========================================================================
    // Next state
    always_comb begin
        n        = s;
        enable   = s.control[ssw_pkg::ENABLE_BIT];
        rx_only  = s.control[ssw_pkg::RX_ONLY_BIT];
        clk_src  = s.control[1:0];
        rd_start = 1'b0;
        fifo_pop = 1'b0;
        ext_rise = 1'b0;
        ext_fall = 1'b0;
        tgl      = 1'b0;
        sck_fall = 1'b0;
        sck_rise = 1'b0;
        div_last = ssw_pkg::DIV_LO_LAST;

        // Pin synchronisers: a change counts once stages two and three agree
        n.tmr_prev = timer_clock_output;
        n.sck_sync = {s.sck_sync[1:0], serial_clock_pin_i};
        n.din_sync = {s.din_sync[1:0],
                      s.wire_mode ? data_out_pin_i : data_in_pin_i};
        if (s.sck_sync[1] == s.sck_sync[2]
                && s.sck_sync[2] != s.sck_stable) begin
            n.sck_stable = s.sck_sync[2];
            ext_rise     = s.sck_sync[2];
            ext_fall     = !s.sck_sync[2];
        end
        if (s.din_sync[1] == s.din_sync[2]) begin
            n.din_stable = s.din_sync[2];
        end

        // Write address and data are taken in either order
        if (awvalid && s.aw_rdy) begin
            n.aw_rdy = 1'b0;
            n.aw_idx = awaddr[19:2];
        end
        if (wvalid && s.w_rdy) begin
            n.w_rdy   = 1'b0;
            n.w_data  = wdata[7:0];
            n.w_lane0 = wstrb[0];
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        do_write      = !s.aw_rdy && !s.w_rdy && !s.bvalid;
        // Only an enabled transmit-mode write queues a byte
        fifo_in_valid = do_write && s.aw_idx == ssw_pkg::IDX_SHIFT
                        && s.w_lane0 && enable && !rx_only;
        if (do_write && (!fifo_in_valid || fifo_in_ready)) begin
            n.aw_rdy = 1'b1;
            n.w_rdy  = 1'b1;
            n.bvalid = 1'b1;
            n.bresp  = ssw_pkg::RESP_OKAY;
            case (s.aw_idx)
                ssw_pkg::IDX_CONTROL: begin
                    if (s.w_lane0) begin
                        n.control = s.w_data & ssw_pkg::CONTROL_MASK;
                    end
                end
                ssw_pkg::IDX_WIRE_MODE: begin
                    if (s.w_lane0) begin
                        n.wire_mode = s.w_data[0];
                    end
                end
                ssw_pkg::IDX_PORT_DIR: begin
                    if (s.w_lane0) begin
                        n.port_dir = s.w_data[1:0];
                    end
                end
                ssw_pkg::IDX_STATUS: begin
                    if (s.w_lane0 && s.w_data[ssw_pkg::DONE_BIT]) begin
                        n.done = 1'b0;
                    end
                end
                ssw_pkg::IDX_SHIFT: begin
                    // Stored only; a later enable does not send it
                    if (s.w_lane0 && !fifo_in_valid
                            && s.state == ssw_pkg::ST_IDLE) begin
                        n.sh = s.w_data;
                    end
                end
                default: begin
                    n.bresp = ssw_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel: one read under way at a time
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.ar_rdy = 1'b1;
        end
        if (arvalid && s.ar_rdy) begin
            n.ar_rdy = 1'b0;
            n.rvalid = 1'b1;
            n.rresp  = ssw_pkg::RESP_OKAY;
            n.rdata  = 8'h00;
            case (araddr[19:2])
                ssw_pkg::IDX_CONTROL:   n.rdata = s.control;
                ssw_pkg::IDX_WIRE_MODE: n.rdata = {7'h00, s.wire_mode};
                ssw_pkg::IDX_PORT_DIR:  n.rdata = {6'h00, s.port_dir};
                ssw_pkg::IDX_STATUS: begin
                    n.rdata = {6'h00, s.state == ssw_pkg::ST_SHIFT, s.done};
                end
                ssw_pkg::IDX_SHIFT: begin
                    n.rdata  = s.sh;
                    rd_start = enable && rx_only
                               && s.state == ssw_pkg::ST_IDLE;
                end
                default: n.rresp = ssw_pkg::RESP_SLVERR;
            endcase
        end

        // Shift clock source
        if (clk_src == ssw_pkg::CLK_DIV_HI) begin
            div_last = ssw_pkg::DIV_HI_LAST;
        end
        case (clk_src)
            ssw_pkg::CLK_EXTERNAL: begin
                sck_fall = ext_fall;
                sck_rise = ext_rise;
            end
            ssw_pkg::CLK_TIMER: begin
                tgl = timer_clock_output && !s.tmr_prev;
            end
            default: begin
                tgl = (s.div == div_last);
            end
        endcase
        if (clk_src != ssw_pkg::CLK_EXTERNAL) begin
            sck_fall = tgl && s.sck;
            sck_rise = tgl && !s.sck;
        end

        // Transfer engine
        case (s.state)
            ssw_pkg::ST_IDLE: begin
                n.div = '0;
                n.cnt = '0;
                n.sck = 1'b1;
                if (enable && !rx_only && fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    n.sh     = fifo_out_data;
                    n.state  = ssw_pkg::ST_SHIFT;
                end else if (rd_start) begin
                    n.state = ssw_pkg::ST_SHIFT;
                end
            end
            ssw_pkg::ST_SHIFT: begin
                n.div = (s.div == div_last) ? 7'h00 : s.div + 7'h01;
                if (sck_fall) begin
                    n.sck     = (clk_src == ssw_pkg::CLK_EXTERNAL);
                    n.out_bit = s.sh[7];
                    n.sh      = {s.sh[6:0], 1'b0};
                end
                if (sck_rise) begin
                    n.sck   = 1'b1;
                    n.sh[0] = n.din_stable;
                    n.cnt   = s.cnt + 4'h1;
                    if (s.cnt == ssw_pkg::XFER_BITS - 4'h1) begin
                        n.state = ssw_pkg::ST_IDLE;
                        n.done  = 1'b1;
                    end
                end
            end
            default: begin
                n.state = ssw_pkg::ST_IDLE;
            end
        endcase

        // Disabled: counter cleared, shifter stopped, pins released
        if (!enable) begin
            n.state = ssw_pkg::ST_IDLE;
            n.cnt   = '0;
            n.div   = '0;
            n.sck   = 1'b1;
        end
        // Receive-only keeps the data output latch low
        if (rx_only) begin
            n.out_bit = 1'b0;
        end
        n.sck_oe  = enable && clk_src != ssw_pkg::CLK_EXTERNAL
                    && !s.port_dir[ssw_pkg::CLK_DIR_BIT];
        n.dout_oe = enable && !rx_only
                    && !s.port_dir[ssw_pkg::DATA_DIR_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= S_RESET;
        end else begin
            s <= n;
        end
    end

    // ========================================================================
    // Outputs
    always_comb begin
        awready             = s.aw_rdy;
        wready              = s.w_rdy;
        bvalid              = s.bvalid;
        bresp               = s.bresp;
        arready             = s.ar_rdy;
        rvalid              = s.rvalid;
        rresp               = s.rresp;
        rdata               = {24'h00_0000, s.rdata};
        serial_clock_pin_o  = s.sck;
        serial_clock_pin_oe = s.sck_oe;
        data_out_pin_o      = s.out_bit;
        data_out_pin_oe     = s.dout_oe;
    end

endmodule

// ### ssw_serial_port_checker.sv
// Bound assertions on the serial port's bus and pin behaviour
`timescale 1ns/1ps

module ssw_port_checker (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus channels
    input wire logic [19:0] awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    // Serial pins
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe,
    input wire logic        data_out_pin_o,
    input wire logic        data_out_pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ========================================================================
    // Bus
    AST_B_HOLD: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata)) else $error("read answer dropped");
    AST_R_LAT: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer not one cycle later");
    AST_R_TOP: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    AST_B_LAT: assert property (awvalid && awready && wvalid && wready
        && (!bvalid || bready) && awaddr[19:2] != ssw_pkg::IDX_SHIFT
        |=> !awready && !wready && !bvalid ##1 bvalid)
        else $error("write answer late");

    // ========================================================================
    // Pins
    AST_RST_PINS: assert property (disable iff (1'b0)
        !aresetn |=> serial_clock_pin_o && !serial_clock_pin_oe
        && !data_out_pin_oe) else $error("pins not released in reset");
    AST_DATA_FALL: assert property (
        data_out_pin_oe && $past(data_out_pin_oe) && serial_clock_pin_oe
        && $changed(data_out_pin_o) |-> $fell(serial_clock_pin_o))
        else $error("data out moved off a falling clock");
    AST_SCK_LOW: assert property (
        serial_clock_pin_oe && $fell(serial_clock_pin_o) |=>
        !serial_clock_pin_o [*3]) else $error("clock low phase too short");
    AST_SCK_IDLE: assert property (
        !serial_clock_pin_oe |-> serial_clock_pin_o)
        else $error("internal clock not high while undriven");
endmodule

bind ssw_serial_port ssw_port_checker u_chk (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp,
    .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .serial_clock_pin_o, .serial_clock_pin_oe, .data_out_pin_o,
    .data_out_pin_oe);

// ### ssw_peer.sv
// Behavioural peripheral on the far side of the serial link
`timescale 1ns/1ps

module ssw_peer #(
    parameter int HALF = 8
) (
    // Serial wires
    input  wire logic       sck,
    input  wire logic       sdo,
    output logic            sdi,
    output logic            ext_sck,
    // Bench side
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte
);
    int k = 0;

    initial begin
        sdi = 1'b1;
        ext_sck = 1'b1;
        rx_byte = 8'h00;
    end

    // Next bit goes out after each falling edge, most significant first
    always @(negedge sck) begin
        sdi = tx_byte[3'(7 - k)];
        k = (k + 1) % 8;
    end

    always @(posedge sck) begin
        rx_byte = {rx_byte[6:0], sdo};
    end

    // Offset keeps clock edges away from the system clock edges
    always @(posedge go) begin
        #3;
        repeat (8) begin
            #(HALF * 8) ext_sck = 1'b0;
            #(HALF * 8) ext_sck = 1'b1;
        end
    end
endmodule

// ### test_sync_serial_two_three_wire.sv
// Self-checking bench for the two/three-wire serial port
`timescale 1ns/1ps

module test_sync_serial_two_three_wire;
    typedef struct packed {
        logic       two;
        logic [7:0] ctl;
        logic [7:0] dat;
        logic [7:0] half;
        logic [7:0] dexp;
    } ssw_row_type;

    // ========================================================================
    // Signals
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [19:0] awaddr = 20'h0_0000;
    logic [19:0] araddr = 20'h0_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic        sck_o, sck_oe, sd_o, sd_oe, sdi, ext_sck;
    logic        timer = 1'b0, go = 1'b0, two = 1'b0;
    logic [1:0]  tcnt = 2'h0;
    logic [7:0]  peer_tx = 8'h00, peer_rx, rv;
    int          errors = 0, samples_checked = 0, falls = 0, lat;
    realtime     t0, t1;
    wire         sck_w = sck_oe ? sck_o : ext_sck;
    wire         sd_w = sd_oe ? sd_o : sdi;

    ssw_row_type rows [7] = '{
        '{1'b0, 8'h82, 8'ha5, 8'h04, 8'h5a},
        '{1'b0, 8'h83, 8'h3c, 8'h40, 8'hc3},
        '{1'b0, 8'h81, 8'h96, 8'h06, 8'h69},
        '{1'b0, 8'h80, 8'h0f, 8'h08, 8'hf0},
        '{1'b0, 8'h86, 8'h71, 8'h04, 8'h8e},
        '{1'b1, 8'h82, 8'he1, 8'h04, 8'he1},
        '{1'b1, 8'h86, 8'h2b, 8'h04, 8'hd4}};

    ssw_serial_port u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe(sck_oe), .data_out_pin_i(sd_w),
        .data_out_pin_o(sd_o), .data_out_pin_oe(sd_oe),
        .data_in_pin_i(two ? ~sdi : sdi), .timer_clock_output(timer));

    ssw_peer #(.HALF(8)) u_peer (
        .sck(sck_w), .sdo(sd_w), .sdi(sdi), .ext_sck(ext_sck), .go(go),
        .tx_byte(peer_tx), .rx_byte(peer_rx));

    // ========================================================================
    // Clock, timer and link watchers
    always #4 aclk = ~aclk;

    // Timer rises every six system clocks
    always @(posedge aclk) begin
        tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
        if (tcnt == 2'h2) timer <= ~timer;
    end

    always @(negedge sck_w) begin
        if (falls == 0) t0 = $realtime;
        falls++;
    end

    always @(posedge sck_w) t1 = $realtime;

    // ========================================================================
    // Tasks
    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            errors++;
            give_verdict();
        end
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic w(input logic [17:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        lat = 0;
        do begin
            @(posedge aclk);
            lat++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && lat < 3000);
        tmo(lat, 3000);
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic r(input logic [17:0] idx);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 3000);
        tmo(n, 3000);
        rready <= 1'b0;
        rv = rdata[7:0];
        rs = rresp;
    endtask

    task automatic rc(input logic [17:0] idx, input logic [7:0] e);
        r(idx);
        cmp({rs, rv}, {ssw_pkg::RESP_OKAY, e});
    endtask

    // Waits for done with busy clear after n falling edges on the link
    task automatic poll(input int n);
        int i;
        i = 0;
        do begin
            r(ssw_pkg::IDX_STATUS);
            i++;
        end while (!(rv[1:0] === 2'b01 && falls >= n) && i < 4000);
        tmo(i, 4000);
    endtask

    task automatic xfer(input ssw_row_type c);
        two <= c.two;
        w(ssw_pkg::IDX_WIRE_MODE, {7'h00, c.two});
        w(ssw_pkg::IDX_PORT_DIR, {7'h00, c.ctl[1:0] == 2'h0});
        w(ssw_pkg::IDX_STATUS, 8'h01);
        w(ssw_pkg::IDX_CONTROL, c.ctl);
        peer_tx <= ~c.dat;
        falls = 0;
        if (c.ctl[2]) r(ssw_pkg::IDX_SHIFT);
        else w(ssw_pkg::IDX_SHIFT, c.dat);
        cmp({sck_oe, sd_oe}, {c.ctl[1:0] != 2'h0, !c.ctl[2]});
        if (c.ctl[1:0] == 2'h0) go <= 1'b1;
        poll(8);
        go <= 1'b0;
        cmp(falls, 8);
        cmp(int'(t1 - t0), 15 * 8 * c.half);
        if (!c.ctl[2]) cmp(peer_rx, c.dat);
        w(ssw_pkg::IDX_CONTROL, 8'h00);
        repeat (2) @(posedge aclk);
        cmp({sck_o, sck_oe, sd_oe}, 3'b100);
        rc(ssw_pkg::IDX_SHIFT, c.dexp);
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) xfer(rows[i]);
        // Second reset, then register defaults and masks
        aresetn <= 1'b0;
        two <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        cmp({sck_o, sck_oe, sd_oe}, 3'b100);
        rc(ssw_pkg::IDX_CONTROL, 8'h00);
        rc(ssw_pkg::IDX_WIRE_MODE, 8'h00);
        w(ssw_pkg::IDX_CONTROL, 8'h7c);
        rc(ssw_pkg::IDX_CONTROL, 8'h04);
        w(ssw_pkg::IDX_WIRE_MODE, 8'hfe);
        rc(ssw_pkg::IDX_WIRE_MODE, 8'h00);
        w(18'h0_0000, 8'h55);
        cmp(rs, ssw_pkg::RESP_SLVERR);
        r(18'h0_0000);
        cmp({rs, rv}, {ssw_pkg::RESP_SLVERR, 8'h00});
        // Shift write while disabled must not start later
        w(ssw_pkg::IDX_CONTROL, 8'h02);
        w(ssw_pkg::IDX_SHIFT, 8'h77);
        w(ssw_pkg::IDX_CONTROL, 8'h82);
        falls = 0;
        repeat (100) @(posedge aclk);
        cmp(falls, 0);
        rc(ssw_pkg::IDX_STATUS, 8'h00);
        // Disable in mid-frame under an external clock
        w(ssw_pkg::IDX_PORT_DIR, 8'h01);
        w(ssw_pkg::IDX_CONTROL, 8'h80);
        w(ssw_pkg::IDX_SHIFT, 8'h5a);
        go <= 1'b1;
        repeat (40) @(posedge aclk);
        w(ssw_pkg::IDX_CONTROL, 8'h00);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
        cmp({sck_oe, sd_oe}, 2'b00);
        rc(ssw_pkg::IDX_STATUS, 8'h00);
        repeat (150) @(posedge aclk);
        rc(ssw_pkg::IDX_STATUS, 8'h00);
        // Fill the FIFO behind a slow clock until a write stalls
        w(ssw_pkg::IDX_PORT_DIR, 8'h00);
        w(ssw_pkg::IDX_CONTROL, 8'h83);
        falls = 0;
        for (int i = 0; i < 10; i++) w(ssw_pkg::IDX_SHIFT, 8'(8'h10 + i));
        cmp(lat > 500, 1);
        poll(80);
        cmp(falls, 80);
        cmp(peer_rx, 8'h19);
        rc(ssw_pkg::IDX_STATUS, 8'h01);
        give_verdict();
    end
endmodule
